// ### rsxw_pkg.sv
package rsxw_pkg;
	// ----------------------------------------
	// Opcode patterns
	// ----------------------------------------
	localparam logic [5:0]  OPC_ROTATE_RIGHT_HI = 6'h0C;
	localparam logic [5:0]  OPC_SUB_HI      = 6'h02;
	localparam logic [5:0]  OPC_SWAP_HI     = 6'h0E;
	localparam logic [5:0]  OPC_XOR_HI      = 6'h06;
	localparam logic [11:0] OPC_WDT_RESTART = 12'h004;
	localparam int          OPC_W           = 12;
	localparam int          DATA_W          = 8;
	localparam int          REG_SEL_W       = 5;
	localparam int          DEST_BIT        = 5;
	localparam int          NUM_REGS        = 32;
	// ----------------------------------------
	// APB register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] ADDR_CTRL       = 12'h000;
	localparam logic [11:0] ADDR_INSTR      = 12'h004;
	localparam logic [11:0] ADDR_ACCUM      = 12'h008;
	localparam logic [11:0] ADDR_STATUS     = 12'h00C;
	localparam logic [11:0] ADDR_PC         = 12'h010;
	localparam logic [11:0] ADDR_FILE_BASE  = 12'h080;
	// STATUS field positions
	localparam int          ST_CARRY        = 0;
	localparam int          ST_ZERO         = 1;
	localparam int          ST_NCARRY       = 2;
	localparam int          ST_TIMEOUT      = 3;
	localparam int          ST_PWRDN        = 4;
	// CTRL field positions
	localparam int          CTRL_PRE_WDT    = 0;
	localparam int          CTRL_WDT_CLR    = 1;
	localparam int          CTRL_PRE_CLR    = 2;
	// Reset values
	localparam logic [7:0]  STATUS_RST      = 8'h18;
	localparam logic [7:0]  ACCUM_RST       = 8'h00;
	localparam logic [10:0] PC_RST          = 11'h000;
	// ----------------------------------------
	// Operation kinds
	// ----------------------------------------
	typedef enum logic [2:0] {
		RSXW_OP_NONE,
		RSXW_OP_ROTATE_RIGHT,
		RSXW_OP_WDT,
		RSXW_OP_SUB,
		RSXW_OP_SWAP,
		RSXW_OP_XOR
	} rsxw_op_t;
endpackage : rsxw_pkg

// ### rsxw_decode.sv
`timescale 1ns/1ps
module rsxw_decode
	import rsxw_pkg::*;
(
	input  wire logic [OPC_W-1:0]     opcode,
	output rsxw_op_t                  op_kind,
	output logic      [REG_SEL_W-1:0] reg_sel,
	output logic                      dest_reg
);
	wire logic [5:0] hi = opcode[11:6];

	assign reg_sel  = opcode[REG_SEL_W-1:0];
	assign dest_reg = opcode[DEST_BIT];
	assign op_kind  = (opcode == OPC_WDT_RESTART) ? RSXW_OP_WDT :
	                  (hi == OPC_ROTATE_RIGHT_HI) ? RSXW_OP_ROTATE_RIGHT :
	                  (hi == OPC_SUB_HI)  ? RSXW_OP_SUB  :
	                  (hi == OPC_SWAP_HI) ? RSXW_OP_SWAP :
	                  (hi == OPC_XOR_HI)  ? RSXW_OP_XOR  :
	                  RSXW_OP_NONE;
endmodule : rsxw_decode

// ### rsxw_alu.sv
`timescale 1ns/1ps
module rsxw_alu
	import rsxw_pkg::*;
(
	input  rsxw_op_t                op_kind,
	input  wire logic [DATA_W-1:0]  reg_val,
	input  wire logic [DATA_W-1:0]  accum,
	input  wire logic               carry_in,
	output logic      [DATA_W-1:0]  result,
	output logic                    carry_out,
	output logic                    zero_out
);
	wire logic [DATA_W:0] diff = {1'b0, reg_val} - {1'b0, accum};

	always_comb begin
		result    = reg_val;
		carry_out = carry_in;
		unique case (op_kind)
			RSXW_OP_ROTATE_RIGHT: begin
				result    = {carry_in, reg_val[DATA_W-1:1]};
				carry_out = reg_val[0];
			end
			RSXW_OP_SUB: begin
				result    = diff[DATA_W-1:0];
				carry_out = ~diff[DATA_W];                     // No borrow sets carry
			end
			RSXW_OP_SWAP: result = {reg_val[3:0], reg_val[7:4]};
			RSXW_OP_XOR:  result = reg_val ^ accum;
			RSXW_OP_WDT, RSXW_OP_NONE: result = reg_val;
		endcase
	end

	assign zero_out = (result == '0);
endmodule : rsxw_alu

// ### rsxw_core.sv
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module rsxw_core
	import rsxw_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             wdt_clear,
	output logic             prescaler_clear
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [DATA_W-1:0] file_r [NUM_REGS];
	logic [DATA_W-1:0] accum_r;
	logic [7:0]        status_r;
	logic [10:0]       pc_r;
	logic              pre_wdt_r;
	logic              wdt_clr_r;
	logic              pre_clr_r;
	logic [31:0]       prdata_r;
	logic              pslverr_r;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic word_hit(
		input logic [11:0] addr,
		input logic [11:0] base
	);
		return addr == base;
	endfunction : word_hit

	function automatic logic op_has_result(
		input rsxw_op_t kind
	);
		unique case (kind)
			RSXW_OP_ROTATE_RIGHT,
			RSXW_OP_SUB,
			RSXW_OP_SWAP,
			RSXW_OP_XOR: return 1'b1;
			default:     return 1'b0;
		endcase
	endfunction : op_has_result

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire logic        acc_phase  = psel & penable;
	wire logic        wr_en      = acc_phase & pwrite;
	wire logic        rd_en      = acc_phase & ~pwrite;
	wire logic        hit_ctrl   = word_hit(paddr, ADDR_CTRL);
	wire logic        hit_instr  = word_hit(paddr, ADDR_INSTR);
	wire logic        hit_accum  = word_hit(paddr, ADDR_ACCUM);
	wire logic        hit_status = word_hit(paddr, ADDR_STATUS);
	wire logic        hit_pc     = word_hit(paddr, ADDR_PC);
	wire logic        hit_file   = (paddr[11:7] == ADDR_FILE_BASE[11:7]) & (paddr[1:0] == 2'b00);
	wire logic [4:0]  file_idx   = paddr[6:2];
	wire logic        hit_any    = hit_ctrl | hit_instr | hit_accum | hit_status | hit_pc | hit_file;
	wire logic        exec       = wr_en & hit_instr;

	// ----------------------------------------
	// Decode and execute
	// ----------------------------------------
	rsxw_op_t          op_kind;
	logic [4:0]        reg_sel;
	logic              dest_reg;
	logic [DATA_W-1:0] alu_res;
	logic              alu_c;
	logic              alu_z;

	rsxw_decode u_dec (
		.opcode   (pwdata[OPC_W-1:0]),
		.op_kind  (op_kind),
		.reg_sel  (reg_sel),
		.dest_reg (dest_reg)
	);

	rsxw_alu u_alu (
		.op_kind   (op_kind),
		.reg_val   (file_r[reg_sel]),
		.accum     (accum_r),
		.carry_in  (status_r[ST_CARRY]),
		.result    (alu_res),
		.carry_out (alu_c),
		.zero_out  (alu_z)
	);

	wire logic is_alu   = op_has_result(op_kind);
	wire logic wr_acc   = exec & is_alu & ~dest_reg;
	wire logic wr_file  = exec & is_alu & dest_reg;
	wire logic is_wdt   = exec & (op_kind == RSXW_OP_WDT);

	// Status update per instruction
	logic [7:0] status_nxt;
	always_comb begin
		status_nxt = status_r;
		if (exec) begin
			unique case (op_kind)
				RSXW_OP_ROTATE_RIGHT: begin
					status_nxt[ST_CARRY] = alu_c;
				end
				RSXW_OP_SUB: begin
					status_nxt[ST_CARRY]  = alu_c;
					status_nxt[ST_NCARRY] = ~alu_c;
					status_nxt[ST_ZERO]   = alu_z;
				end
				RSXW_OP_XOR: begin
					status_nxt[ST_ZERO] = alu_z;
				end
				RSXW_OP_WDT: begin
					status_nxt[ST_TIMEOUT] = 1'b1;
					status_nxt[ST_PWRDN]   = 1'b1;
				end
				RSXW_OP_SWAP,
				RSXW_OP_NONE: begin
					status_nxt = status_r;
				end
			endcase
		end else if (wr_en & hit_status) begin
			status_nxt = pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	logic [DATA_W-1:0]   accum_nxt;
	logic [10:0]         pc_nxt;
	logic [NUM_REGS-1:0] file_we;
	logic [DATA_W-1:0]   file_nxt;
	logic                pre_wdt_nxt;
	logic                wdt_clr_nxt;
	logic                pre_clr_nxt;
	logic [31:0]         prdata_nxt;
	logic                pslverr_nxt;
	logic [31:0]         rd_mux;

	// ----------------------------------------
	// Execution qualifiers
	// ----------------------------------------
	// Undecoded opcodes leave the program counter alone
	wire logic setup_ph   = psel & ~penable;
	wire logic exec_known = exec & (op_has_result(op_kind) | (op_kind == RSXW_OP_WDT));

	// ----------------------------------------
	// Accumulator
	// ----------------------------------------
	always_comb begin
		accum_nxt = accum_r;
		if (wr_acc) begin
			accum_nxt = alu_res;
		end else if (wr_en & hit_accum) begin
			accum_nxt = pwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			accum_r <= ACCUM_RST;
		end else begin
			accum_r <= accum_nxt;
		end
	end

	// ----------------------------------------
	// Status
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= STATUS_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	// ----------------------------------------
	// Program counter
	// ----------------------------------------
	always_comb begin
		pc_nxt = pc_r;
		if (exec_known) begin
			pc_nxt = pc_r + 11'h001;
		end else if (wr_en & hit_pc) begin
			pc_nxt = pwdata[10:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc_r <= PC_RST;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	// ----------------------------------------
	// File registers
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_file_we
			assign file_we[gi] = (wr_file & (reg_sel == 5'(gi))) |
			                     (wr_en & hit_file & (file_idx == 5'(gi)));
		end
	endgenerate

	assign file_nxt = wr_file ? alu_res : pwdata[DATA_W-1:0];

	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_file
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					file_r[gi] <= '0;
				end else if (file_we[gi]) begin
					file_r[gi] <= file_nxt;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Watchdog and prescaler clear pulses
	// ----------------------------------------
	// One cycle after the restart executes
	assign wdt_clr_nxt = is_wdt;
	assign pre_clr_nxt = is_wdt & pre_wdt_r;
	assign pre_wdt_nxt = (wr_en & hit_ctrl) ? pwdata[CTRL_PRE_WDT] : pre_wdt_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pre_wdt_r <= 1'b0;
			wdt_clr_r <= 1'b0;
			pre_clr_r <= 1'b0;
		end else begin
			pre_wdt_r <= pre_wdt_nxt;
			wdt_clr_r <= wdt_clr_nxt;
			pre_clr_r <= pre_clr_nxt;
		end
	end

	assign wdt_clear       = wdt_clr_r;
	assign prescaler_clear = pre_clr_r;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Instruction register reads back zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux = {29'h0, pre_clr_r, wdt_clr_r, pre_wdt_r};
		end else if (hit_accum) begin
			rd_mux = {24'h0, accum_r};
		end else if (hit_status) begin
			rd_mux = {24'h0, status_r};
		end else if (hit_pc) begin
			rd_mux = {21'h0, pc_r};
		end else if (hit_file) begin
			rd_mux = {24'h0, file_r[file_idx]};
		end
	end

	assign prdata_nxt  = pwrite ? 32'h0000_0000 : rd_mux;
	assign pslverr_nxt = ~hit_any;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ----------------------------------------
	// Bus outputs
	// ----------------------------------------
	assign prdata  = rd_en ? prdata_r : 32'h0000_0000;
	assign pready  = 1'b1;
	assign pslverr = acc_phase & pslverr_r;
endmodule : rsxw_core

// ### rsxw_checker.sv
`timescale 1ns/1ps
module rsxw_checker
	import rsxw_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        wdt_clear,
	input wire logic        prescaler_clear
);
	// ----
	// Helper logic
	// ----
	logic pre_wdt_r;
	wire  acc_ph  = psel && penable;
	wire  wdt_req = acc_ph && pwrite && paddr == ADDR_INSTR && pwdata[OPC_W-1:0] == OPC_WDT_RESTART;
	wire  mapped  = (paddr <= ADDR_PC || paddr[11:7] == 5'h01) && paddr[1:0] == 2'h0;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			pre_wdt_r <= 1'b0;
		else if (acc_ph && pwrite && paddr == ADDR_CTRL)
			pre_wdt_r <= pwdata[CTRL_PRE_WDT];
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_wdt_exec;
		wdt_req;
	endsequence
	sequence s_pulse;
		wdt_clear ##1 !wdt_clear;
	endsequence
	a_wdt_follows: assert property (s_wdt_exec |=> s_pulse)
		else $error("watchdog clear pulse missing");
	a_wdt_cause: assert property (wdt_clear |-> $past(wdt_req))
		else $error("watchdog clear without restart");
	a_pre_assigned: assert property (wdt_clear |-> prescaler_clear == pre_wdt_r)
		else $error("prescaler clear disagrees with assignment");
	a_pre_only_wdt: assert property (prescaler_clear |-> wdt_clear)
		else $error("prescaler clear alone");
	a_unmapped_err: assert property (acc_ph && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc_ph && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_ready_high: assert property (acc_ph |-> pready)
		else $error("wait state inserted");
	a_prdata_idle: assert property (!(acc_ph && !pwrite) |-> prdata == 32'h0)
		else $error("read data outside read access");
endmodule : rsxw_checker

bind rsxw_core rsxw_checker i_rsxw_checker (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .wdt_clear(wdt_clear), .prescaler_clear(prescaler_clear));

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
	import rsxw_pkg::*;
	logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, wdt_clear, prescaler_clear, e;
	logic [10:0] pc_e = 11'h000;
	int          miscompares = 0, n_compared = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	rsxw_core i_rsxw_core (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wdt_clear(wdt_clear), .prescaler_clear(prescaler_clear));
	task summarize;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, x, g);
		end
	endtask : chk
	// ----
	// APB master
	// ----
	task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xf
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		xf(1'b0, a, 32'h0);
		chk("prdata", x, q);
	endtask : rd
	function automatic logic [11:0] fa(input logic [4:0] r);
		return ADDR_FILE_BASE + {5'h00, r, 2'h0};
	endfunction : fa
	task automatic ex(input logic [11:0] op, input logic [7:0] rv, acc, st, res, est);
		xf(1'b1, fa(op[4:0]), {24'h0, rv});
		xf(1'b1, ADDR_ACCUM, {24'h0, acc});
		xf(1'b1, ADDR_STATUS, {24'h0, st});
		xf(1'b1, ADDR_INSTR, {20'h0, op});
		pc_e++;
		rd(fa(op[4:0]), {24'h0, op[DEST_BIT] ? res : rv});
		rd(ADDR_ACCUM, {24'h0, op[DEST_BIT] ? acc : res});
		rd(ADDR_STATUS, {24'h0, est});
		rd(ADDR_PC, {21'h0, pc_e});
	endtask : ex
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		rd(ADDR_STATUS, 32'h18);
		ex(12'h325, 8'h81, 8'h33, 8'h02, 8'h40, 8'h03);
		ex(12'h31F, 8'h02, 8'h33, 8'h01, 8'h81, 8'h00);
		ex(12'h09F, 8'h10, 8'h10, 8'h00, 8'h00, 8'h03);
		ex(12'h0A0, 8'h05, 8'h10, 8'h01, 8'hF5, 8'h04);
		ex(12'h380, 8'hA5, 8'h00, 8'h07, 8'h5A, 8'h07);
		ex(12'h1A2, 8'h5A, 8'h5A, 8'h05, 8'h00, 8'h07);
		ex(12'h182, 8'h0F, 8'hF0, 8'h02, 8'hFF, 8'h00);
		for (int i = 0; i < 2; i++) begin
			xf(1'b1, ADDR_CTRL, {31'h0, i == 0});
			xf(1'b1, ADDR_STATUS, 32'h0);
			xf(1'b1, ADDR_INSTR, {20'h0, OPC_WDT_RESTART});
			pc_e++;
			@(posedge mclk);
			chk("wdt_clear", 32'h1, {31'h0, wdt_clear});
			chk("prescaler_clear", {31'h0, i == 0}, {31'h0, prescaler_clear});
			rd(ADDR_STATUS, 32'h18);
			rd(ADDR_PC, {21'h0, pc_e});
		end
		xf(1'b1, ADDR_INSTR, 32'h0);
		rd(ADDR_PC, {21'h0, pc_e});
		xf(1'b0, 12'h040, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		summarize();
	end
endmodule : testbench
